// ---- brz_pkg.sv ----
// Purpose: constants and carrier types of the balance rate and zero command block
// Assumes: 250 MHz mclk, APB register access, 32-bit data
// Notes:   rate in milli-values per second, period in whole milliseconds
//
// Overview of operation
// [R01] Rate setting paces repeating weight output pulses
// [R02] Rate query answers A with configured rate
// [R03] Accepted rate setting answers bare A
// [R04] Busy device answers I, setting unchanged
// [R05] Rate outside 0.1..100 or malformed gives L
// [R06] Round to realizable rate, report actual value
// [R07] Host baud at least 220 times rate
// [R08] Rate persists; default only by command/reset
// [R09] Stable zero sets new zero, answers A
// [R10] Stable zero answers I on busy/timeout
// [R11] Stable zero answers plus/minus outside range
// [R12] Power-on zero and ranges never change
// [R13] Successful zeroing clears stored tare
// [R14] Immediate zero: D if dynamic, S stable
// [R15] Immediate zero answers I while busy
// [R16] Immediate zero answers plus/minus outside range
// [R17] Approved variant refuses immediate zero
// [R18] Identification message pending after power-up
// [R19] Both ends same baud, bits, parity
// [R20] Handshake blocks sending unless disabled
// [R21] Codes above 127 need 8-bit framing
// [R22] Lines end CR LF, single-space separators
package brz_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0]  ADDR_CMD      = 8'h00;
  localparam logic [7:0]  ADDR_PARAM    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_REPLY    = 8'h0C;
  localparam logic [7:0]  ADDR_RATE     = 8'h10;
  localparam logic [7:0]  ADDR_PERIOD   = 8'h14;
  localparam logic [7:0]  ADDR_TARE     = 8'h18;
  localparam logic [7:0]  ADDR_GROSS    = 8'h1C;
  localparam logic [7:0]  ADDR_NET      = 8'h20;
  localparam logic [7:0]  ADDR_LINKCFG  = 8'h24;
  localparam logic [7:0]  ADDR_TXCHAR   = 8'h28;
  localparam logic [7:0]  ADDR_SERIAL   = 8'h2C;
  // ==========================================================
  // Status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_REPLY   = 1;
  localparam int ST_IDPEND  = 2;
  localparam int ST_REPEAT  = 3;
  localparam int ST_UNIT    = 4;
  localparam int ST_TXOK    = 5;
  localparam int ST_BAUDLOW = 6;
  localparam int ST_APPROV  = 7;
  localparam int PARAM_BAD  = 31;
  // ==========================================================
  // Reply characters
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_L     = 8'h4C;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  // ==========================================================
  // Rate and timing
  localparam logic [16:0] RATE_MIN_MILLI = 17'd100;
  localparam logic [16:0] RATE_MAX_MILLI = 17'd100000;
  localparam logic [20:0] RATE_NUM       = 21'd1000000;
  localparam logic [13:0] PERIOD_DEFAULT = 14'd100;
  localparam logic [13:0] PERIOD_MIN     = 14'd10;
  localparam logic [13:0] PERIOD_MAX     = 14'd10000;
  localparam int          MCLK_HZ        = 250000000;
  localparam int          TICK_MS_CYCLES = MCLK_HZ / 1000;
  localparam logic [47:0] BAUD_LIMIT     = 48'd250000000000;
  localparam logic [7:0]  BAUD_FACTOR    = 8'd220;
  localparam int          ZERO_TIMEOUT_MS = 3000;
  localparam logic signed [24:0] ZERO_HI = 25'sd100000;
  localparam logic signed [24:0] ZERO_LO = -25'sd20000;
  localparam logic [31:0] SERIAL_DEFAULT = 32'h00000000;
  // ==========================================================
  // Carrier types
  typedef enum logic [3:0] {
    OP_RATE_QUERY, OP_RATE_SET, OP_RATE_DEFAULT, OP_ZERO,
    OP_ZERO_NOW, OP_REPEAT, OP_REPEAT_UNIT, OP_REPEAT_STOP
  } brz_op_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } brz_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } brz_apb_rsp_t;
  typedef struct packed {
    logic signed [23:0] rawWeight;
    logic               stable;
    logic               busyOther;
  } brz_scale_t;
endpackage : brz_pkg

// ---- brz_rate_zero.sv ----
// Purpose: rate setting, zeroing and status replies behind an APB slave
// Assumes: firmware parses command text and writes opcode and parameter
// Notes:   one wait state on every APB access
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module brz_rate_zero
#(
  parameter int TICK_CYCLES = brz_pkg::TICK_MS_CYCLES,
  parameter int ZERO_TMO_MS = brz_pkg::ZERO_TIMEOUT_MS
)
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire brz_pkg::brz_apb_req_t apbReq,
  output      brz_pkg::brz_apb_rsp_t apbRsp,
  input  wire brz_pkg::brz_scale_t   scaleIn,
  input  wire logic                  ctsPin,
  input  wire logic                  approvedPin,
  input  wire logic [13:0]           storedPeriod,
  input  wire logic                  storedValid,
  input  wire logic                  paramReset,
  output      logic                  persistWr,
  output      logic [13:0]           persistPeriod,
  output      logic                  repeatPulse,
  output      logic                  repeatUnit,
  output      logic                  txPermit,
  output      logic signed [23:0]    grossWeight,
  output      logic signed [23:0]    netWeight
);
  import brz_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [2:0] {S_LOAD, S_IDLE, S_DIV_PER, S_DIV_RATE, S_ZERO_WAIT} brz_fsm_t;
  typedef struct packed {
    brz_fsm_t           fsm;
    brz_apb_rsp_t       rsp;
    logic [31:0]        param;
    logic               replyQuiet;
    logic [7:0]         replyChar;
    logic               replyValid;
    logic [2:0]         txIdx;
    logic               idPend;
    logic [16:0]        rateMilli;
    logic [13:0]        period;
    logic [20:0]        divNum;
    logic [20:0]        divRem;
    logic [20:0]        divQuo;
    logic [4:0]         divCnt;
    logic signed [23:0] tare;
    logic signed [23:0] workZero;
    logic signed [23:0] powerZero;
    logic               powerZeroOk;
    logic [15:0]        baudDiv;
    logic               eightBit;
    logic [1:0]         parity;
    logic               hsEn;
    logic               baudLow;
    logic [2:0]         ctsSync;
    logic               ctsLevel;
    logic [2:0]         apvSync;
    logic               approved;
    logic [17:0]        tickCnt;
    logic [13:0]        msCnt;
    logic [13:0]        zeroMs;
    logic               repeatOn;
    logic               unit;
    logic               pulse;
    logic               persistWr;
    logic               txPermit;
    logic signed [23:0] gross;
    logic signed [23:0] net;
  } brz_state_t;

  brz_state_t s_reg;
  brz_state_t s_next;

  // ==========================================================
  // Helpers
  function automatic logic [8:0] frameChar(input logic [7:0] c, input logic eight);
    frameChar = eight ? {1'b0, c} : {c[7], 1'b0, c[6:0]};
  endfunction : frameChar

  function automatic logic [1:0] rangeCheck(input logic signed [24:0] d);
    rangeCheck = {d > ZERO_HI, d < ZERO_LO};
  endfunction : rangeCheck

  logic               apbAccess;
  logic               apbWrite;
  logic               apbRead;
  logic [31:0]        readMux;
  logic               mapped;
  logic               tickNow;
  logic signed [24:0] zeroDiff;
  logic [1:0]         zeroRange;
  logic [47:0]        baudNeed;
  logic [7:0]         txSeq;
  logic [20:0]        remShift;
  logic [8:0]         txFramed;
  brz_op_t            op;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_next    = s_reg;
    apbAccess = apbReq.psel & apbReq.penable & s_reg.rsp.pready;
    apbWrite  = apbAccess & apbReq.pwrite;
    apbRead   = apbAccess & ~apbReq.pwrite;
    op        = brz_op_t'(apbReq.pwdata[3:0]);
    tickNow   = s_reg.tickCnt == 18'(TICK_CYCLES - 1);
    zeroDiff  = 25'(scaleIn.rawWeight) - 25'(s_reg.powerZero);
    zeroRange = rangeCheck(zeroDiff);
    baudNeed  = 48'(s_reg.baudDiv) * 48'(BAUD_FACTOR) * 48'(s_reg.rateMilli);
    remShift  = {s_reg.divRem[19:0], s_reg.divNum[20]};
    case (s_reg.txIdx)
      3'd0:    txSeq = CH_SP;
      3'd1:    txSeq = s_reg.replyChar;
      3'd2:    txSeq = CH_CR;
      default: txSeq = CH_LF;
    endcase
    txFramed = frameChar(txSeq, s_reg.eightBit);
    mapped   = 1'b1;
    case (apbReq.paddr)
      ADDR_CMD:     readMux = 32'h00000000;
      ADDR_PARAM:   readMux = s_reg.param;
      ADDR_STATUS:  readMux = {24'h000000, s_reg.approved, s_reg.baudLow, s_reg.txPermit,
                               s_reg.unit, s_reg.repeatOn, s_reg.idPend, s_reg.replyValid,
                               s_reg.fsm != S_IDLE};
      ADDR_REPLY:   readMux = {23'h000000, s_reg.replyValid, s_reg.replyChar};
      ADDR_RATE:    readMux = {15'h0000, s_reg.rateMilli};
      ADDR_PERIOD:  readMux = {18'h00000, s_reg.period};
      ADDR_TARE:    readMux = 32'(s_reg.tare);
      ADDR_GROSS:   readMux = 32'(s_reg.gross);
      ADDR_NET:     readMux = 32'(s_reg.net);
      ADDR_LINKCFG: readMux = {12'h000, s_reg.hsEn, s_reg.parity, s_reg.eightBit, s_reg.baudDiv};
      ADDR_TXCHAR:  readMux = {21'h000000, s_reg.replyValid & (s_reg.txIdx < 3'd4),
                               txFramed[8], 1'b0, txFramed[7:0]};
      ADDR_SERIAL:  readMux = SERIAL_DEFAULT;
      default:
      begin
        readMux = 32'h00000000;
        mapped  = 1'b0;
      end
    endcase

    // APB slave, one wait state
    s_next.rsp.pready  = apbReq.psel & apbReq.penable & ~s_reg.rsp.pready;
    s_next.rsp.pslverr = 1'b0;
    if (apbReq.psel & apbReq.penable & ~s_reg.rsp.pready)
    begin
      s_next.rsp.prdata  = apbReq.pwrite ? 32'h00000000 : readMux;
      s_next.rsp.pslverr = ~mapped;
    end

    // Pin synchronisers, change taken when stages two and three agree
    s_next.ctsSync = {s_reg.ctsSync[1:0], ctsPin};
    s_next.apvSync = {s_reg.apvSync[1:0], approvedPin};
    if (s_reg.ctsSync[1] == s_reg.ctsSync[2])
      s_next.ctsLevel = s_reg.ctsSync[2];
    if (s_reg.apvSync[1] == s_reg.apvSync[2])
      s_next.approved = s_reg.apvSync[2];
    s_next.txPermit = ~s_reg.hsEn | s_reg.ctsLevel; // [R20]
    s_next.baudLow  = baudNeed > BAUD_LIMIT; // [R07]

    // Working weights; power-on zero taken once only
    if (!s_reg.powerZeroOk)
    begin
      s_next.powerZero   = scaleIn.rawWeight; // [R12]
      s_next.workZero    = scaleIn.rawWeight;
      s_next.powerZeroOk = 1'b1;
    end
    s_next.gross = scaleIn.rawWeight - s_reg.workZero;
    s_next.net   = scaleIn.rawWeight - s_reg.workZero - s_reg.tare;

    // Millisecond tick and repeat pacing
    s_next.tickCnt = tickNow ? 18'h00000 : s_reg.tickCnt + 18'h00001;
    s_next.pulse   = 1'b0;
    if (tickNow)
    begin
      if (s_reg.msCnt >= s_reg.period - 14'h0001)
      begin
        s_next.msCnt = 14'h0000;
        s_next.pulse = s_reg.repeatOn; // [R01]
      end
      else
        s_next.msCnt = s_reg.msCnt + 14'h0001;
    end

    // Register writes
    s_next.persistWr = 1'b0;
    if (apbWrite)
    begin
      case (apbReq.paddr)
        ADDR_PARAM:   s_next.param = apbReq.pwdata;
        ADDR_TARE:    s_next.tare  = apbReq.pwdata[23:0];
        ADDR_LINKCFG:
        begin
          s_next.baudDiv  = apbReq.pwdata[15:0]; // [R19]
          s_next.eightBit = apbReq.pwdata[16]; // [R21]
          s_next.parity   = apbReq.pwdata[18:17];
          s_next.hsEn     = apbReq.pwdata[19];
        end
        ADDR_STATUS:
        begin
          if (apbReq.pwdata[ST_IDPEND])
            s_next.idPend = 1'b0;
          if (apbReq.pwdata[ST_REPLY])
            s_next.replyValid = 1'b0;
        end
        default: s_next.param = s_reg.param;
      endcase
    end
    if (apbRead && apbReq.paddr == ADDR_TXCHAR && s_reg.replyValid && s_reg.txIdx < 3'd4)
      s_next.txIdx = s_reg.txIdx + 3'd1; // [R22]

    // Command engine
    case (s_reg.fsm)
      S_LOAD:
      begin
        if (storedValid && storedPeriod >= PERIOD_MIN && storedPeriod <= PERIOD_MAX)
          s_next.period = storedPeriod; // [R08]
        else
          s_next.period = PERIOD_DEFAULT;
        s_next.replyQuiet = 1'b1;
        s_next.divNum     = RATE_NUM + 21'(s_next.period >> 1);
        s_next.divRem     = 21'h000000;
        s_next.divCnt     = 5'd0;
        s_next.fsm        = S_DIV_RATE;
      end
      S_DIV_PER, S_DIV_RATE:
      begin
        s_next.divNum = {s_reg.divNum[19:0], 1'b0};
        if (remShift >= (s_reg.fsm == S_DIV_PER ? 21'(s_reg.param[16:0]) : 21'(s_reg.period)))
        begin
          s_next.divRem = remShift - (s_reg.fsm == S_DIV_PER ? 21'(s_reg.param[16:0])
                                                               : 21'(s_reg.period));
          s_next.divQuo = {s_reg.divQuo[19:0], 1'b1};
        end
        else
        begin
          s_next.divRem = remShift;
          s_next.divQuo = {s_reg.divQuo[19:0], 1'b0};
        end
        s_next.divCnt = s_reg.divCnt + 5'd1;
        if (s_reg.divCnt == 5'd20)
        begin
          s_next.divRem = 21'h000000;
          s_next.divCnt = 5'd0;
          if (s_reg.fsm == S_DIV_PER)
          begin
            s_next.period        = s_next.divQuo[13:0]; // [R06]
            s_next.persistWr     = 1'b1; // [R08]
            s_next.divNum        = RATE_NUM + 21'(s_next.divQuo[13:1]);
            s_next.fsm           = S_DIV_RATE;
          end
          else
          begin
            s_next.rateMilli = s_next.divQuo[16:0]; // [R06]
            s_next.fsm       = S_IDLE;
            if (!s_reg.replyQuiet)
            begin
              s_next.replyChar  = CH_A; // [R03]
              s_next.replyValid = 1'b1;
              s_next.txIdx      = 3'd0;
            end
          end
        end
      end
      S_ZERO_WAIT:
      begin
        if (tickNow)
          s_next.zeroMs = s_reg.zeroMs + 14'h0001;
        if (scaleIn.busyOther || (tickNow && s_reg.zeroMs == 14'(ZERO_TMO_MS - 1)))
        begin
          s_next.replyChar = CH_I; // [R10]
          s_next.fsm       = S_IDLE;
        end
        else if (scaleIn.stable)
        begin
          s_next.fsm = S_IDLE;
          if (zeroRange[1])
            s_next.replyChar = CH_PLUS; // [R11]
          else if (zeroRange[0])
            s_next.replyChar = CH_MINUS; // [R11]
          else
          begin
            s_next.workZero  = scaleIn.rawWeight; // [R09] [R12]
            s_next.tare      = 24'sh000000; // [R13]
            s_next.replyChar = CH_A; // [R09]
          end
        end
        if (s_next.fsm == S_IDLE)
        begin
          s_next.replyValid = 1'b1;
          s_next.txIdx      = 3'd0;
        end
      end
      default:
      begin
        if (paramReset)
        begin
          s_next.param[16:0] = 17'h00000;
          s_next.period      = PERIOD_DEFAULT; // [R08]
          s_next.persistWr   = 1'b1;
          s_next.replyQuiet  = 1'b1;
          s_next.divNum      = RATE_NUM + 21'(PERIOD_DEFAULT >> 1);
          s_next.fsm         = S_DIV_RATE;
        end
      end
    endcase

    // New command: busy engine answers I and changes nothing
    if (apbWrite && apbReq.paddr == ADDR_CMD)
    begin
      s_next.replyValid = 1'b1;
      s_next.txIdx      = 3'd0;
      if (s_reg.fsm != S_IDLE || paramReset)
        s_next.replyChar = CH_I; // [R04] [R15]
      else
      begin
        s_next.replyQuiet = 1'b0;
        s_next.replyValid = 1'b0;
        case (op)
          OP_RATE_QUERY:
          begin
            s_next.replyChar  = CH_A; // [R02]
            s_next.replyValid = 1'b1;
          end
          OP_RATE_SET:
          begin
            s_next.replyValid = 1'b1;
            if (scaleIn.busyOther)
              s_next.replyChar = CH_I; // [R04]
            else if (s_reg.param[PARAM_BAD] || s_reg.param[30:17] != 14'h0000
                     || s_reg.param[16:0] < RATE_MIN_MILLI
                     || s_reg.param[16:0] > RATE_MAX_MILLI)
              s_next.replyChar = CH_L; // [R05]
            else
            begin
              s_next.replyValid = 1'b0;
              s_next.divNum     = RATE_NUM + 21'(s_reg.param[16:1]);
              s_next.divRem     = 21'h000000;
              s_next.divCnt     = 5'd0;
              s_next.fsm        = S_DIV_PER;
            end
          end
          OP_RATE_DEFAULT:
          begin
            s_next.period    = PERIOD_DEFAULT; // [R08]
            s_next.persistWr = 1'b1;
            s_next.divNum    = RATE_NUM + 21'(PERIOD_DEFAULT >> 1);
            s_next.divRem    = 21'h000000;
            s_next.divCnt    = 5'd0;
            s_next.fsm       = S_DIV_RATE;
          end
          OP_ZERO:
          begin
            if (scaleIn.busyOther)
            begin
              s_next.replyChar  = CH_I; // [R10]
              s_next.replyValid = 1'b1;
            end
            else
            begin
              s_next.zeroMs = 14'h0000;
              s_next.fsm    = S_ZERO_WAIT;
            end
          end
          OP_ZERO_NOW:
          begin
            s_next.replyValid = 1'b1;
            if (s_reg.approved)
              s_next.replyChar = CH_E; // [R17]
            else if (scaleIn.busyOther)
              s_next.replyChar = CH_I; // [R15]
            else if (zeroRange[1])
              s_next.replyChar = CH_PLUS; // [R16]
            else if (zeroRange[0])
              s_next.replyChar = CH_MINUS; // [R16]
            else
            begin
              s_next.workZero  = scaleIn.rawWeight; // [R14] [R12]
              s_next.tare      = 24'sh000000; // [R13]
              s_next.replyChar = scaleIn.stable ? CH_S : CH_D; // [R14]
            end
          end
          OP_REPEAT, OP_REPEAT_UNIT:
          begin
            s_next.repeatOn   = 1'b1; // [R01]
            s_next.unit       = (op == OP_REPEAT_UNIT);
            s_next.msCnt      = 14'h0000;
            s_next.replyChar  = CH_A;
            s_next.replyValid = 1'b1;
          end
          OP_REPEAT_STOP:
          begin
            s_next.repeatOn   = 1'b0;
            s_next.replyChar  = CH_A;
            s_next.replyValid = 1'b1;
          end
          default:
          begin
            s_next.replyChar  = CH_E;
            s_next.replyValid = 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg        <= '0;
      s_reg.fsm    <= S_LOAD;
      s_reg.idPend <= 1'b1; // [R18]
      s_reg.period <= PERIOD_DEFAULT;
      s_reg.eightBit <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================
  // Outputs
  assign apbRsp        = s_reg.rsp;
  assign persistWr     = s_reg.persistWr;
  assign persistPeriod = s_reg.period;
  assign repeatPulse   = s_reg.pulse;
  assign repeatUnit    = s_reg.unit;
  assign txPermit      = s_reg.txPermit;
  assign grossWeight   = s_reg.gross;
  assign netWeight     = s_reg.net;
endmodule : brz_rate_zero

// ---- brz_rate_zero_sva.sv ----
// Purpose: concurrent checks on brz_rate_zero ports
// Assumes: one clock domain, active-low async reset
// Notes:   attached by bind below the module
`timescale 1ns/1ns
module brz_rate_zero_sva
  import brz_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire brz_pkg::brz_apb_req_t apbReq,
  input wire brz_pkg::brz_apb_rsp_t apbRsp,
  input wire logic                  ctsPin,
  input wire logic                  persistWr,
  input wire logic [13:0]           persistPeriod,
  input wire logic                  repeatPulse,
  input wire logic                  repeatUnit,
  input wire logic                  txPermit
);
  logic wrDone;
  assign wrDone = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ======
  // Bus steps
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_access;
    apbReq.psel && apbReq.penable;
  endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |=> apbRsp.pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("pslverr without pready");
  a_repeat_gap: assert property (repeatPulse |=> !repeatPulse [*8])
    else $error("repeat pulses too close");
  a_persist_one: assert property (persistWr |=> !persistWr)
    else $error("persist strobe too long");
  a_period_range: assert property (
    persistPeriod >= PERIOD_MIN && persistPeriod <= PERIOD_MAX)
    else $error("period outside realizable range");
  a_tx_follow: assert property (ctsPin [*6] |-> txPermit)
    else $error("transmit blocked with handshake high");
  a_unit_cause: assert property ($changed(repeatUnit) |->
    $past(wrDone) || $past(wrDone, 2) || $past(wrDone, 3))
    else $error("unit mode changed without a write");
endmodule : brz_rate_zero_sva

bind brz_rate_zero brz_rate_zero_sva chkI (.mclk(mclk), .resetn(resetn), .apbReq(apbReq),
  .apbRsp(apbRsp), .ctsPin(ctsPin), .persistWr(persistWr), .persistPeriod(persistPeriod),
  .repeatPulse(repeatPulse), .repeatUnit(repeatUnit), .txPermit(txPermit));

// ---- brz_host_model.sv ----
// Purpose: host side of the serial link
// Assumes: handshake level set by the bench
// Notes:   measures spacing of repeated outputs
`timescale 1ns/1ns
module brz_host_model
(
  input  wire logic mclk,
  input  wire logic ctsOn,
  input  wire logic repeatPulse,
  output      logic ctsPin,
  output      int   gap
);
  int cnt = 0;
  assign ctsPin = ctsOn;
  always @(posedge mclk)
  begin
    cnt <= repeatPulse ? 1 : cnt + 1;
    if (repeatPulse)
      gap <= cnt;
  end
endmodule : brz_host_model

// ---- test_brz_rate_zero.sv ----
// Purpose: self-checking bench for brz_rate_zero
// Assumes: one wait state APB slave, 4 cycles per ms
// Notes:   power-on zero taken at raw 1000
`timescale 1ns/1ns
module test_brz_rate_zero;
  import brz_pkg::*;
  logic               mclk, resetn, ctsOn, apr, prst, pw, rp, ru, tp, cts, err;
  brz_apb_req_t       req;
  brz_apb_rsp_t       rsp;
  brz_scale_t         sc;
  logic [13:0]        pp;
  logic signed [23:0] gw, nw;
  logic [31:0]        rd;
  int                 badCount = 0, checkCount = 0, cyc = 0, gap;
  logic [31:0]        badPar[3] = '{32'd99, 32'd100001, 32'h80004E20};
  logic [31:0]        lineCh[5] = '{32'h420, 32'h441, 32'h40D, 32'h40A, 32'h00A};
  logic [13:0]        nv = 14'h0000;
  logic               nvOk = 1'b0;
  brz_rate_zero #(.TICK_CYCLES(4), .ZERO_TMO_MS(5)) uut (.mclk(mclk), .resetn(resetn),
    .apbReq(req), .apbRsp(rsp), .scaleIn(sc), .ctsPin(cts), .approvedPin(apr),
    .storedPeriod(nv), .storedValid(nvOk), .paramReset(prst), .persistWr(pw),
    .persistPeriod(pp), .repeatPulse(rp), .repeatUnit(ru), .txPermit(tp),
    .grossWeight(gw), .netWeight(nw));
  brz_host_model host (.mclk(mclk), .ctsOn(ctsOn), .repeatPulse(rp), .ctsPin(cts), .gap(gap));
  // Nonvolatile store of the period
  always @(posedge mclk)
    if (pw)
    begin
      nv   <= pp;
      nvOk <= 1'b1;
    end
  // ======
  // Tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
      @(posedge mclk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : xfer
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rc
  task automatic cmd(input logic [3:0] op, input logic [31:0] par, input logic [7:0] e);
    int n = 0;
    xfer(1'b1, ADDR_PARAM, par);
    xfer(1'b1, ADDR_CMD, {28'h0, op});
    do
    begin
      xfer(1'b0, ADDR_REPLY, 32'h0);
      n++;
    end
    while (rd[8] !== 1'b1 && n < 40);
    chk(rd[7:0], e);
    xfer(1'b1, ADDR_STATUS, 32'h2);
  endtask : cmd
  // ======
  // Clock, timeout, sequence
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      badCount++;
      summarize();
    end
  end
  initial
  begin
    resetn = 0;
    req = '0;
    sc = '{24'sd1000, 1'b1, 1'b0};
    ctsOn = 1;
    apr = 0;
    prst = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1;
    repeat (30) @(posedge mclk);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[2], 1);
    rc(ADDR_PERIOD, 100);
    cmd(0, 0, CH_A);
    rc(ADDR_RATE, 10000);
    cmd(1, 18311, CH_A);
    rc(ADDR_PERIOD, 55);
    rc(ADDR_RATE, 18182);
    foreach (badPar[i])
      cmd(1, badPar[i], CH_L);
    cmd(1, 100, CH_A);
    rc(ADDR_PERIOD, 10000);
    cmd(1, 100000, CH_A);
    sc.busyOther <= 1;
    cmd(1, 20000, CH_I);
    rc(ADDR_PERIOD, 10);
    cmd(3, 0, CH_I);
    cmd(4, 0, CH_I);
    sc.busyOther <= 0;
    $display("rate test done");
    resetn <= 0;
    repeat (2) @(posedge mclk);
    resetn <= 1;
    repeat (30) @(posedge mclk);
    rc(ADDR_PERIOD, 10);
    rc(ADDR_RATE, 100000);
    chk(pp, 10);
    xfer(1'b1, ADDR_CMD, 32'h5);
    repeat (150) @(posedge mclk);
    chk(gap, 40);
    xfer(1'b1, ADDR_CMD, 32'h6);
    repeat (5) @(posedge mclk);
    chk(ru, 1);
    xfer(1'b1, ADDR_CMD, 32'h7);
    foreach (lineCh[i])
      rc(ADDR_TXCHAR, lineCh[i]);
    xfer(1'b1, ADDR_STATUS, 32'h2);
    $display("repeat test done");
    xfer(1'b1, ADDR_TARE, 32'd77);
    sc.rawWeight <= 24'sd1500;
    cmd(3, 0, CH_A);
    rc(ADDR_GROSS, 0);
    chk(gw, 0);
    rc(ADDR_TARE, 0);
    sc.rawWeight <= 24'sd101001;
    cmd(3, 0, CH_PLUS);
    cmd(4, 0, CH_PLUS);
    sc.rawWeight <= -24'sd19001;
    cmd(3, 0, CH_MINUS);
    cmd(4, 0, CH_MINUS);
    sc <= '{24'sd1200, 1'b0, 1'b0};
    cmd(3, 0, CH_I);
    cmd(4, 0, CH_D);
    rc(ADDR_NET, 0);
    chk(nw, 0);
    sc.stable <= 1;
    cmd(4, 0, CH_S);
    apr <= 1;
    repeat (6) @(posedge mclk);
    cmd(4, 0, CH_E);
    $display("zero test done");
    xfer(1'b1, ADDR_LINKCFG, 32'h0009FFFF);
    ctsOn <= 0;
    repeat (8) @(posedge mclk);
    chk(tp, 0);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[6], 1);
    xfer(1'b0, 8'h3C, 32'h0);
    chk(err, 1);
    cmd(2, 0, CH_A);
    rc(ADDR_RATE, 10000);
    cmd(1, 20000, CH_A);
    rc(ADDR_PERIOD, 50);
    prst <= 1;
    @(posedge mclk);
    prst <= 0;
    repeat (60) @(posedge mclk);
    rc(ADDR_PERIOD, 100);
    $display("link test done");
    summarize();
  end
endmodule : test_brz_rate_zero
